/* File: prs_ctl_model.sv */
// bus controller model for the sensor's serial pins
`timescale 1ns/1ps
module prs_ctl_model (
  // clock
  input wire mclk_i,
  // bus lines
  input wire sda_i,
  output reg scl_o,
  output reg sda_low_o
);
  integer b;
  reg r;
  initial begin
    scl_o = 1;
    sda_low_o = 0;
  end
  // 40 clocks per bit, a 160 ns bus clock
  task w(input integer n);
    begin
      repeat (n) @(posedge mclk_i);
      #1;
    end
  endtask
  // sda released before scl rises so a repeated start is never seen as stop
  task st;
    begin
      sda_low_o = 0;
      w(5);
      scl_o = 1;
      w(10);
      sda_low_o = 1;
      w(10);
      scl_o = 0;
    end
  endtask
  task sp;
    begin
      sda_low_o = 1;
      w(10);
      scl_o = 1;
      w(10);
      sda_low_o = 0;
      w(20);
    end
  endtask
  // data bits then the ack bit; nak high releases the ack slot
  task xfer(input [7:0] d, input nak, output [7:0] q, output ack);
    begin
      for (b = 8; b >= 0; b = b - 1) begin
        sda_low_o = (b > 0) ? !d[b-1] : !nak;
        w(10);
        scl_o = 1;
        w(10);
        r = sda_i;
        if (b > 0) q[b-1] = r;
        w(10);
        scl_o = 0;
        w(10);
      end
      ack = !r;
    end
  endtask
endmodule

/* File: prs_i2c_target.v */
// serial target of the pressure sensor with its result fifo
// How it works
// - first command accepted once supply is good for 1 ms.
// - first measurement may start once supply is good for 2.5 ms.
// - clear pin pulse resets bus and measurement state (not the result fifo) and reruns power-up sequence.
// - clear pin active low; only high-low-high pulse triggers the reset.
// - pure bus target; never starts a transfer.
// - answers its own 7-bit address, default 0x18.
// - address selectable among 0x08,0x28,0x38,0x48,0x58,0x68,0x78.
// - read: start, address, read bit; ack, then up to 4 bytes.
// - read returns status byte first, then 24-bit pressure.
// - status bit 6 shows power; bits 7,4,3,1 read zero.
// - status bit 5 busy until the last command's result is ready.
// - commands arriving while busy are dropped.
// - status bit 2 is memory checksum fail, taken at power-up only.
// - status bit 0 flags arithmetic saturation of the result.
// - command leaves standby; back to standby after the measurement.
// - handles 100 and 400 kbit/s bus rates.
`timescale 1ns/1ps
`include "prs_regs.vh"

module prs_fifo #(
  parameter W = 25,
  parameter D = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire mclk_i,
  input wire rst_i,
  input wire ce_i,
  // fill side
  input wire in_valid_i,
  input wire [W-1:0] in_data_i,
  output wire in_ready_o,
  // drain side
  output wire out_valid_o,
  output wire [W-1:0] out_data_o,
  input wire out_ready_i
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_ff;
  reg [AW-1:0] rp_ff;
  reg [AW:0] cnt_ff;
  reg nfull_ff;
  reg nempty_ff;
  wire push = in_valid_i & nfull_ff;
  wire pop = out_ready_i & nempty_ff;
  wire [AW:0] nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign in_ready_o = nfull_ff;
  assign out_valid_o = nempty_ff;
  assign out_data_o = mem[rp_ff];
  always @(posedge mclk_i) begin
    if (ce_i && push) begin
      mem[wp_ff] <= in_data_i;
    end
  end
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_ff <= {AW{1'b0}};
      rp_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
      nfull_ff <= 1'b1;
      nempty_ff <= 1'b0;
    end else if (ce_i) begin
      if (push) begin
        wp_ff <= (wp_ff == D - 1) ? {AW{1'b0}} : wp_ff + 1'b1;
      end
      if (pop) begin
        rp_ff <= (rp_ff == D - 1) ? {AW{1'b0}} : rp_ff + 1'b1;
      end
      cnt_ff <= nxt_cnt;
      nfull_ff <= (nxt_cnt != D);
      nempty_ff <= (nxt_cnt != {(AW+1){1'b0}});
    end
  end
endmodule

module prs_i2c_target #(
  parameter [19:0] CMD_CYC = `PRS_CMD_CYC,
  parameter [19:0] MEAS_CYC = `PRS_MEAS_CYC,
  parameter RES_W = `PRS_RES_W,
  parameter RES_D = `PRS_RES_D
) (
  // clock, reset, enable
  input wire mclk_i,
  input wire rst_i,
  input wire ce_i,
  // pins
  input wire supply_rail_ok_i,
  input wire external_clear_pin_n_i,
  input wire [2:0] addr_sel_i,
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_o,
  // conversion side
  input wire mem_check_ok_i,
  input wire res_valid_i,
  input wire [RES_W-1:0] res_data_i,
  output wire res_ready_o,
  output reg meas_start_o,
  output reg operating_o
);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_AACK = 3'h2;
  localparam [2:0] S_WR = 3'h3;
  localparam [2:0] S_WACK = 3'h4;
  localparam [2:0] S_RD = 3'h5;
  localparam [2:0] S_RACK = 3'h6;

  // pin synchronisers
  reg [1:0] scl_s_ff;
  reg [1:0] sda_s_ff;
  reg [1:0] sup_s_ff;
  reg [1:0] clr_s_ff;
  reg [5:0] asel_s1_ff;
  reg scl_d_ff;
  reg sda_d_ff;
  reg clr_d_ff;
  // power-up and measurement state
  reg [19:0] pu_cnt_ff;
  reg mem_err_ff;
  reg busy_ff;
  reg started_ff;
  reg sat_ff;
  reg [23:0] press_ff;
  // bus engine
  reg [2:0] st_ff;
  reg [3:0] bit_ff;
  reg [7:0] sh_ff;
  reg rw_ff;
  reg nack_ff;
  reg [2:0] idx_ff;
  reg [1:0] nwr_ff;
  reg cmd_bad_ff;

  wire scl = scl_s_ff[1];
  wire sda = sda_s_ff[1];
  wire [2:0] asel = asel_s1_ff[5:3];
  wire scl_rise = scl & ~scl_d_ff;
  wire scl_fall = ~scl & scl_d_ff;
  wire start_c = scl & scl_d_ff & sda_d_ff & ~sda;
  wire stop_c = scl & scl_d_ff & ~sda_d_ff & sda;
  // rising edge of the clear pin after a low phase means a complete pulse
  wire clr_pulse = clr_s_ff[1] & ~clr_d_ff;
  wire powered = sup_s_ff[1];
  wire cmd_ok = powered & (pu_cnt_ff >= CMD_CYC);
  wire meas_ok = powered & (pu_cnt_ff >= MEAS_CYC);
  wire [7:0] status = {1'b0, powered, busy_ff, 2'b00, mem_err_ff, 1'b0, sat_ff};
  wire [6:0] my_addr;
  wire fifo_valid;
  wire [RES_W-1:0] fifo_data;
  wire take_res = busy_ff & started_ff & fifo_valid;

  function [6:0] addr_of;
    input [2:0] sel;
    begin
      case (sel)
        3'h1: addr_of = `PRS_ADDR_ALT0;
        3'h2: addr_of = `PRS_ADDR_ALT1;
        3'h3: addr_of = `PRS_ADDR_ALT2;
        3'h4: addr_of = `PRS_ADDR_ALT3;
        3'h5: addr_of = `PRS_ADDR_ALT4;
        3'h6: addr_of = `PRS_ADDR_ALT5;
        3'h7: addr_of = `PRS_ADDR_ALT6;
        default: addr_of = `PRS_ADDR_DEFAULT;
      endcase
    end
  endfunction

  // bytes past the fourth read as released bus
  function [7:0] byte_of;
    input [2:0] i;
    input [7:0] s;
    input [23:0] p;
    begin
      case (i)
        3'h0: byte_of = s;
        3'h1: byte_of = p[23:16];
        3'h2: byte_of = p[15:8];
        3'h3: byte_of = p[7:0];
        default: byte_of = `PRS_RD_IDLE;
      endcase
    end
  endfunction

  assign my_addr = addr_of(asel);
  wire [7:0] nxt_byte = byte_of(idx_ff + 3'h1, status, press_ff);

  prs_fifo #(
    .W(RES_W),
    .D(RES_D),
    .AW(4)
  ) u_fifo (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_valid_i(res_valid_i),
    .in_data_i(res_data_i),
    .in_ready_o(res_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(take_res)
  );

  // synchronisers; the first stage feeds only the second
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_s_ff <= 2'h3;
      sda_s_ff <= 2'h3;
      sup_s_ff <= 2'h0;
      clr_s_ff <= 2'h3;
      asel_s1_ff <= 6'h00;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      clr_d_ff <= 1'b1;
    end else if (ce_i) begin
      scl_s_ff <= {scl_s_ff[0], scl_i};
      sda_s_ff <= {sda_s_ff[0], sda_i};
      sup_s_ff <= {sup_s_ff[0], supply_rail_ok_i};
      clr_s_ff <= {clr_s_ff[0], external_clear_pin_n_i};
      asel_s1_ff <= {asel_s1_ff[2:0], addr_sel_i};
      scl_d_ff <= scl;
      sda_d_ff <= sda;
      clr_d_ff <= clr_s_ff[1];
    end
  end

  // power-up sequence and measurement control
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pu_cnt_ff <= 20'h00000;
      mem_err_ff <= 1'b0;
      busy_ff <= 1'b0;
      started_ff <= 1'b0;
      sat_ff <= 1'b0;
      press_ff <= 24'h000000;
      meas_start_o <= 1'b0;
      operating_o <= 1'b0;
    end else if (ce_i) begin
      meas_start_o <= 1'b0;
      if (clr_pulse || !powered) begin
        // same state as power-on: sequence restarts from zero
        pu_cnt_ff <= 20'h00000;
        mem_err_ff <= 1'b0;
        busy_ff <= 1'b0;
        started_ff <= 1'b0;
        sat_ff <= 1'b0;
        press_ff <= 24'h000000;
        operating_o <= 1'b0;
      end else begin
        if (pu_cnt_ff < MEAS_CYC) begin
          pu_cnt_ff <= pu_cnt_ff + 20'h00001;
        end
        // checksum result caught once, when commands become legal
        if (pu_cnt_ff == CMD_CYC - 20'h00001) begin
          mem_err_ff <= ~mem_check_ok_i;
        end
        // the scl rise ahead of the stop has already counted one bit
        if (stop_c && st_ff == S_WR && nwr_ff == `PRS_CMD_LEN && !cmd_bad_ff && bit_ff == 4'h1
            && cmd_ok && !busy_ff) begin
          busy_ff <= 1'b1;
          operating_o <= 1'b1;
        end
        if (busy_ff && !started_ff && meas_ok) begin
          started_ff <= 1'b1;
          meas_start_o <= 1'b1;
        end
        if (take_res) begin
          press_ff <= fifo_data[23:0];
          sat_ff <= fifo_data[24];
          busy_ff <= 1'b0;
          started_ff <= 1'b0;
          operating_o <= 1'b0;
        end
      end
    end
  end

  // bus engine: reacts to clear pulse, power loss, and start, stop and scl edges from the controller
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= S_IDLE;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      rw_ff <= 1'b0;
      nack_ff <= 1'b0;
      idx_ff <= 3'h0;
      nwr_ff <= 2'h0;
      cmd_bad_ff <= 1'b0;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (ce_i) begin
      sda_o <= 1'b0;
      if (clr_pulse || !powered) begin
        st_ff <= S_IDLE;
        sda_oe_o <= 1'b0;
      end else if (start_c) begin
        st_ff <= S_ADDR;
        bit_ff <= 4'h0;
        nwr_ff <= 2'h0;
        cmd_bad_ff <= 1'b0;
        sda_oe_o <= 1'b0;
      end else if (stop_c) begin
        st_ff <= S_IDLE;
        sda_oe_o <= 1'b0;
      end else begin
        case (st_ff)
          S_ADDR: begin
            if (scl_rise) begin
              sh_ff <= {sh_ff[6:0], sda};
              bit_ff <= bit_ff + 4'h1;
            end else if (scl_fall && bit_ff == 4'h8) begin
              if (sh_ff[7:1] == my_addr && cmd_ok) begin
                rw_ff <= sh_ff[0];
                sda_oe_o <= 1'b1;
                st_ff <= S_AACK;
              end else begin
                st_ff <= S_IDLE;
              end
            end
          end
          S_AACK: begin
            if (scl_fall) begin
              bit_ff <= 4'h0;
              if (rw_ff) begin
                idx_ff <= 3'h0;
                sh_ff <= status;
                sda_oe_o <= ~status[7];
                st_ff <= S_RD;
              end else begin
                sda_oe_o <= 1'b0;
                st_ff <= S_WR;
              end
            end
          end
          S_WR: begin
            if (scl_rise) begin
              sh_ff <= {sh_ff[6:0], sda};
              bit_ff <= bit_ff + 4'h1;
            end else if (scl_fall && bit_ff == 4'h8) begin
              if (nwr_ff == 2'h0 && sh_ff != `PRS_CMD_MEAS) begin
                cmd_bad_ff <= 1'b1;
              end
              if (nwr_ff != 2'h0 && sh_ff != `PRS_CMD_DATA) begin
                cmd_bad_ff <= 1'b1;
              end
              if (nwr_ff == `PRS_CMD_LEN) begin
                cmd_bad_ff <= 1'b1;
              end else begin
                nwr_ff <= nwr_ff + 2'h1;
              end
              sda_oe_o <= 1'b1;
              st_ff <= S_WACK;
            end
          end
          S_WACK: begin
            if (scl_fall) begin
              sda_oe_o <= 1'b0;
              bit_ff <= 4'h0;
              st_ff <= S_WR;
            end
          end
          S_RD: begin
            if (scl_rise) begin
              bit_ff <= bit_ff + 4'h1;
            end else if (scl_fall) begin
              if (bit_ff == 4'h8) begin
                sda_oe_o <= 1'b0;
                st_ff <= S_RACK;
              end else begin
                sh_ff <= {sh_ff[6:0], 1'b0};
                sda_oe_o <= ~sh_ff[6];
              end
            end
          end
          S_RACK: begin
            if (scl_rise) begin
              nack_ff <= sda;
            end else if (scl_fall) begin
              bit_ff <= 4'h0;
              if (!nack_ff) begin
                // the byte index holds after four bytes; further bytes are released
                idx_ff <= (idx_ff == `PRS_RD_LEN) ? idx_ff : idx_ff + 3'h1;
                sh_ff <= nxt_byte;
                sda_oe_o <= ~nxt_byte[7];
                st_ff <= S_RD;
              end else begin
                st_ff <= S_IDLE;
              end
            end
          end
          default: begin
            sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

/* File: prs_i2c_target_properties.sv */
// port assertions of the pressure sensor serial target
`timescale 1ns/1ps
module prs_i2c_target_properties (
  // clock and reset
  input wire mclk_i,
  input wire rst_i,
  // pins
  input wire supply_rail_ok_i,
  input wire external_clear_pin_n_i,
  input wire scl_i,
  input wire sda_o,
  input wire sda_oe_o,
  // conversion side
  input wire meas_start_o,
  input wire operating_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_clear_pulse;
    !external_clear_pin_n_i ##1 external_clear_pin_n_i;
  endsequence
  sequence s_power_on;
    !supply_rail_ok_i ##1 supply_rail_ok_i;
  endsequence
  a_only_pull_low: assert property (sda_o == 1'b0)
    else $error("sda data driven high");
  a_start_single: assert property (meas_start_o |=> !meas_start_o)
    else $error("start pulse longer than one cycle");
  a_start_operating: assert property (meas_start_o |-> operating_o)
    else $error("start without operating mode");
  a_drive_scl_low: assert property ($rose(sda_oe_o) |-> !scl_i)
    else $error("sda pulled while scl high");
  // six cycles leave room for the two-stage synchroniser
  a_unpowered_quiet: assert property (!supply_rail_ok_i [*6] |-> !sda_oe_o && !operating_o)
    else $error("activity while unpowered");
  a_clear_restart: assert property (s_clear_pulse |-> ##[1:8] (!sda_oe_o && !operating_o))
    else $error("clear pulse did not reset");
  a_early_nack: assert property (s_power_on |-> !sda_oe_o [*8])
    else $error("bus driven right after power-up");
  a_early_start: assert property (s_power_on |-> !meas_start_o [*8])
    else $error("measurement right after power-up");
endmodule
bind prs_i2c_target prs_i2c_target_properties prs_i2c_target_properties_i (
  .mclk_i(mclk_i), .rst_i(rst_i), .supply_rail_ok_i(supply_rail_ok_i),
  .external_clear_pin_n_i(external_clear_pin_n_i), .scl_i(scl_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .meas_start_o(meas_start_o), .operating_o(operating_o));

/* File: prs_regs.vh */
// constants of the pressure sensor serial target
`ifndef PRS_REGS_VH
`define PRS_REGS_VH
// clock period and start-up times
`define PRS_CLK_NS 4
`define PRS_T_CMD_NS 1000000
`define PRS_T_MEAS_NS 2500000
// start-up times counted in clock cycles
`define PRS_CMD_CYC 20'h3D090
`define PRS_MEAS_CYC 20'h98968
// target addresses
`define PRS_ADDR_DEFAULT 7'h18
`define PRS_ADDR_ALT0 7'h08
`define PRS_ADDR_ALT1 7'h28
`define PRS_ADDR_ALT2 7'h38
`define PRS_ADDR_ALT3 7'h48
`define PRS_ADDR_ALT4 7'h58
`define PRS_ADDR_ALT5 7'h68
`define PRS_ADDR_ALT6 7'h78
// measurement command bytes
`define PRS_CMD_MEAS 8'hAA
`define PRS_CMD_DATA 8'h00
`define PRS_CMD_LEN 2'h3
// measurement_status fields
`define PRS_ST_POWER 6
`define PRS_ST_BUSY 5
`define PRS_ST_MEMERR 2
`define PRS_ST_SAT 0
`define PRS_ST_RESET 8'h00
// read frame
`define PRS_RD_LEN 3'h4
`define PRS_RD_IDLE 8'hFF
// result fifo
`define PRS_RES_W 25
`define PRS_RES_D 16
`endif

/* File: test_prs_i2c_target.sv */
// self-checking bench of the pressure sensor serial target
`timescale 1ns/1ps
module test_prs_i2c_target;
  reg mclk_i = 0;
  reg rst_i = 1;
  reg supply_rail_ok_i = 0;
  reg external_clear_pin_n_i = 1;
  reg mem_check_ok_i = 1;
  reg res_valid_i = 0;
  reg [24:0] res_data_i = 0;
  reg [2:0] addr_sel_i = 0;
  reg [6:0] adr = 7'h18;
  reg [7:0] q;
  reg [7:0] sb = 8'h40;
  reg ack;
  integer n_errors = 0;
  integer checked = 0;
  integer n_starts = 0;
  integer i;
  integer j;
  wire scl;
  wire ctl_low;
  wire sda_oe_o;
  wire res_ready_o;
  wire meas_start_o;
  wire operating_o;
  // open-drain line with pull-up
  wire sda = !(sda_oe_o || ctl_low);
  // small start-up counts keep the run short
  prs_i2c_target #(.CMD_CYC(20'd600), .MEAS_CYC(20'd1500)) prs_i2c_target_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1), .supply_rail_ok_i(supply_rail_ok_i),
    .external_clear_pin_n_i(external_clear_pin_n_i), .addr_sel_i(addr_sel_i),
    .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe_o), .mem_check_ok_i(mem_check_ok_i),
    .res_valid_i(res_valid_i), .res_data_i(res_data_i), .res_ready_o(res_ready_o),
    .meas_start_o(meas_start_o), .operating_o(operating_o));
  prs_ctl_model prs_ctl_model_i (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl),
    .sda_low_o(ctl_low));
  initial begin
    forever #2 mclk_i = !mclk_i;
  end
  // one conversion start per accepted command
  always @(posedge mclk_i) if (meas_start_o === 1'b1) n_starts <= n_starts + 1;
  task chk(input [8*10:1] nm, input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("ERROR %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task nak(input [6:0] a);
    begin
      prs_ctl_model_i.st;
      prs_ctl_model_i.xfer({a, 1'b1}, 1, q, ack);
      prs_ctl_model_i.sp;
      chk("nack", ack, 0);
    end
  endtask
  task rd(input [2:0] n, input [31:0] e);
    begin
      prs_ctl_model_i.st;
      prs_ctl_model_i.xfer({adr, 1'b1}, 1, q, ack);
      chk("addr_ack", ack, 1);
      for (j = 0; j < n; j = j + 1) begin
        prs_ctl_model_i.xfer(8'hFF, j == n - 1, q, ack);
        chk("rd_byte", q, e[31 - 8 * j -: 8]);
      end
      prs_ctl_model_i.sp;
    end
  endtask
  task cmd;
    begin
      prs_ctl_model_i.st;
      prs_ctl_model_i.xfer({adr, 1'b0}, 1, q, ack);
      chk("cmd_ack", ack, 1);
      prs_ctl_model_i.xfer(8'hAA, 1, q, ack);
      prs_ctl_model_i.xfer(8'h00, 1, q, ack);
      prs_ctl_model_i.xfer(8'h00, 1, q, ack);
      prs_ctl_model_i.sp;
    end
  endtask
  task push(input [24:0] d);
    begin
      res_valid_i = 1;
      res_data_i = d;
      @(posedge mclk_i);
      #1 res_valid_i = 0;
      @(posedge mclk_i);
      #1;
    end
  endtask
  task idle;
    begin
      for (j = 0; j < 4000 && operating_o !== 1'b0; j = j + 1) @(posedge mclk_i);
      #1 chk("operating", operating_o, 0);
      q = 8'hFF;
      for (j = 0; j < 8 && q[5] !== 1'b0; j = j + 1) begin
        prs_ctl_model_i.st;
        prs_ctl_model_i.xfer({adr, 1'b1}, 1, q, ack);
        prs_ctl_model_i.xfer(8'hFF, 1, q, ack);
        prs_ctl_model_i.sp;
      end
      chk("busy", q[5], 0);
    end
  endtask
  initial begin
    #400000;
    n_errors = n_errors + 1;
    $display("ERROR watchdog expected end seen hang");
    test_done;
  end
  initial begin
    repeat (10) @(posedge mclk_i);
    #1 rst_i = 0;
    repeat (10) @(posedge mclk_i);
    #1 supply_rail_ok_i = 1;
    nak(adr);
    repeat (300) @(posedge mclk_i);
    #1 $display("test early_nack done");
    for (i = 0; i < 8; i = i + 1) begin
      addr_sel_i = i;
      adr = (i == 0) ? 7'h18 : (i == 1) ? 7'h08 : 7'h08 + 7'h10 * i;
      rd(1, {sb, 24'h0});
      nak(adr ^ 7'h10);
    end
    $display("test address done");
    // pin held low alone changes nothing; its rising edge restarts power-up
    mem_check_ok_i = 0;
    external_clear_pin_n_i = 0;
    rd(1, {sb, 24'h0});
    external_clear_pin_n_i = 1;
    nak(adr);
    repeat (300) @(posedge mclk_i);
    #1 mem_check_ok_i = 1;
    sb = 8'h44;
    rd(1, {sb, 24'h0});
    $display("test clear done");
    cmd;
    chk("operating", operating_o, 1);
    rd(1, {sb | 8'h20, 24'h0});
    cmd;
    push({1'b1, 24'h123456});
    idle;
    rd(4, {sb | 8'h01, 24'h123456});
    chk("starts", n_starts, 1);
    $display("test measure done");
    for (i = 0; i < 20 && res_ready_o === 1'b1; i = i + 1) push({i[0], 4'hA, i[3:0], 16'h0});
    chk("depth", i, 16);
    for (i = 0; i < 16; i = i + 1) begin
      cmd;
      idle;
      rd(2, {sb | i[0], 4'hA, i[3:0], 16'h0});
    end
    chk("starts", n_starts, 17);
    $display("test fifo done");
    test_done;
  end
endmodule
